// [design/sdram_cmd_pkg.sv]
// Purpose: Shared widths, field positions, encodings and timing for the SDRAM command decoder.
// Assumes: A 100 MHz system clock with a 10 ns period.
// Notes: Timing counts are derived from times in nanoseconds.
package sdram_cmd_pkg;
   // ---------------------------------------------------------------
   // Widths of the array and the pins.
   // ---------------------------------------------------------------
   localparam int ROW_W = 11;
   localparam int COL_W = 8;
   localparam int BANK_W = 2;
   localparam int BANKS = 4;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int DATA_W = LANES * LANE_W;
   // ---------------------------------------------------------------
   // Field positions in the address word and the mode register.
   // ---------------------------------------------------------------
   localparam int AUTO_PRE_BIT = 10;
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_BT_BIT = 3;
   localparam int MODE_CL_LSB = 4;
   localparam int MODE_WB_BIT = 9;
   localparam logic [2:0] BL_FULL_PAGE = 3'h7;
   localparam logic [ROW_W-1:0] MODE_RESET = 11'h020;
   localparam logic [1:0] CL_MAX = 2'h3;
   localparam int MASK_LATENCY = 2;
   // ---------------------------------------------------------------
   // Strobe encodings as {row strobe, column strobe, write enable}.
   // ---------------------------------------------------------------
   localparam logic [2:0] ENC_NO_OPERATION = 3'h7;
   localparam logic [2:0] ENC_ACTIVATE = 3'h3;
   localparam logic [2:0] ENC_READ = 3'h5;
   localparam logic [2:0] ENC_WRITE = 3'h4;
   localparam logic [2:0] ENC_BURST_STOP = 3'h6;
   localparam logic [2:0] ENC_PRECHARGE = 3'h2;
   localparam logic [2:0] ENC_REFRESH = 3'h1;
   localparam logic [2:0] ENC_MODE_LOAD = 3'h0;
   // ---------------------------------------------------------------
   // Times and the cycle counts derived from them.
   // ---------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int PRECHARGE_PERIOD_NS = 20;
   localparam int MODE_SET_DELAY_NS = 20;
   localparam int SELF_REFRESH_INTERVAL_NS = 15625;
   localparam int PRECHARGE_PERIOD_CYC = (PRECHARGE_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int MODE_SET_DELAY_CYC = (MODE_SET_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int SELF_REFRESH_CYC = SELF_REFRESH_INTERVAL_NS / CLOCK_PERIOD_NS;
   // ---------------------------------------------------------------
   // Types.
   // ---------------------------------------------------------------
   typedef enum logic [7:0] {
      CMD_NO_OPERATION = 8'h01,
      CMD_ACTIVATE = 8'h02,
      CMD_READ = 8'h04,
      CMD_WRITE = 8'h08,
      CMD_BURST_STOP = 8'h10,
      CMD_PRECHARGE = 8'h20,
      CMD_REFRESH = 8'h40,
      CMD_MODE_LOAD = 8'h80
   } cmd_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_READ = 3'h2,
      ST_WRITE = 3'h4
   } burst_e;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic bank_select_1;
      logic bank_select_0;
      logic [ROW_W-1:0] addr;
   } cmd_pins_s;
endpackage

// [design/sdram_command_decode_banks.sv]
// Purpose: Command decoder, bank row state, burst sequencer and byte masking of an SDRAM device.
// Assumes: All pins are synchronous to clock; the array sits outside behind the mem_ ports.
// Notes: mem_rdata must answer combinationally from mem_bank, mem_row and mem_col.
`timescale 1ns/100ps
module sdram_command_decode_banks import sdram_cmd_pkg::*; #(
   parameter int PRECHARGE_CYC = PRECHARGE_PERIOD_CYC, // Precharge period in cycles.
   parameter int MODE_SET_CYC = MODE_SET_DELAY_CYC, // Mode set delay in cycles.
   parameter int SELF_REF_CYC = SELF_REFRESH_CYC // Self refresh row interval in cycles.
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic cke,
   input wire cmd_pins_s cmd_pins,
   input wire logic [LANES-1:0] dqm,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic [LANES-1:0] dq_oe,
   input wire logic [DATA_W-1:0] mem_rdata,
   output logic [BANK_W-1:0] mem_bank,
   output logic [ROW_W-1:0] mem_row,
   output logic [COL_W-1:0] mem_col,
   output logic mem_we,
   output logic [LANES-1:0] mem_be,
   output logic [DATA_W-1:0] mem_wdata,
   output logic refresh_strobe,
   output logic [ROW_W-1:0] refresh_row,
   output logic self_refresh,
   output logic [ROW_W-1:0] mode_value,
   output logic mode_ready,
   output logic [BANKS-1:0] bank_open,
   output logic [BANKS-1:0] bank_ready
);
   // ---------------------------------------------------------------
   // Declarations.
   // ---------------------------------------------------------------
   localparam int PT_W = $clog2(PRECHARGE_CYC + 1); // Precharge timer width.
   localparam int MT_W = $clog2(MODE_SET_CYC + 1); // Mode delay timer width.
   localparam int ST_W = $clog2(SELF_REF_CYC + 1); // Self refresh divider width.
   cmd_e cmd; // Decoded command of this cycle.
   burst_e state_ff, nxt_state; // Burst sequencer state.
   logic [BANK_W-1:0] bank; // Bank named on the pins.
   logic [BANKS-1:0] open_ff; // Bank holds an open row.
   logic [ROW_W-1:0] row_ff [BANKS]; // Open row of each bank.
   logic [PT_W-1:0] pre_tmr_ff [BANKS]; // Precharge period left per bank.
   logic [MT_W-1:0] mode_tmr_ff; // Mode set delay left.
   logic mode_rdy_ff; // Mode set delay has elapsed, kept as a flop for the output.
   logic [BANKS-1:0] bank_rdy_ff; // Bank idle and precharge period over, kept as flops for the output.
   logic [ROW_W-1:0] mode_ff; // Mode register.
   logic [BANK_W-1:0] bank_ff; // Bank of the running burst.
   logic [ROW_W-1:0] mrow_ff; // Row of the running burst.
   logic [COL_W-1:0] col_ff, start_ff, beat_ff, mask_ff; // Burst address walk.
   logic full_ff, ap_ff; // Full page burst, auto precharge pending.
   logic burst_end; // Last beat of a fixed burst completes now.
   logic [COL_W-1:0] nxt_col; // Next column in burst order.
   logic [LANES-1:0] dqm_p1_ff, dqm_p2_ff; // Read mask delay line.
   logic vp1_ff, vp2_ff; // Read beat history.
   logic [DATA_W-1:0] dp1_ff, dp2_ff; // Read data history.
   logic [3:0] hv; // Read beat history, index is age plus one.
   logic [1:0] cl_eff; // Read latency in use.
   logic drive_ff, valid_ff; // Unmasked drive window and data valid.
   logic [DATA_W-1:0] dq_out_ff, wdata_ff;
   logic [LANES-1:0] dq_oe_ff, be_ff;
   logic [ROW_W-1:0] ref_cnt_ff, ref_row_ff; // Refresh row counter and last row.
   logic ref_stb_ff, self_ff; // Refresh pulse, self refresh mode.
   logic [ST_W-1:0] self_div_ff; // Self refresh row pacing.

   // Burst block mask for each burst length code.
   function automatic logic [COL_W-1:0] block_mask(input logic [2:0] bl);
      unique case (bl)
         3'h0: block_mask = 8'h00;
         3'h1: block_mask = 8'h01;
         3'h2: block_mask = 8'h03;
         3'h3: block_mask = 8'h07;
         default: block_mask = 8'hFF;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Command decode.
   // ---------------------------------------------------------------
   assign bank = {cmd_pins.bank_select_1, cmd_pins.bank_select_0};
   // Self refresh and a high chip select both mask every command.
   always_comb begin
      cmd = CMD_NO_OPERATION;
      if (!cmd_pins.cs_n && !self_ff) begin
         unique case ({cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n})
            ENC_NO_OPERATION: cmd = CMD_NO_OPERATION;
            ENC_ACTIVATE: cmd = CMD_ACTIVATE;
            ENC_READ: cmd = CMD_READ;
            ENC_WRITE: cmd = CMD_WRITE;
            ENC_BURST_STOP: cmd = CMD_BURST_STOP;
            ENC_PRECHARGE: cmd = CMD_PRECHARGE;
            ENC_REFRESH: cmd = CMD_REFRESH;
            ENC_MODE_LOAD: cmd = CMD_MODE_LOAD;
         endcase
         // With clock enable low only the refresh code means anything.
         if (!cke && cmd != CMD_REFRESH) begin
            cmd = CMD_NO_OPERATION;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bank row state and precharge timing.
   // ---------------------------------------------------------------
   // Each bank opens on activate and closes on precharge or auto precharge.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         open_ff <= '0;
         bank_rdy_ff <= '1;
         for (int b = 0; b < BANKS; b++) begin
            row_ff[b] <= '0;
            pre_tmr_ff[b] <= '0;
         end
      end else begin
         for (int b = 0; b < BANKS; b++) begin
            if ((cmd == CMD_PRECHARGE && (cmd_pins.addr[AUTO_PRE_BIT] || bank == BANK_W'(b)))
                || (burst_end && ap_ff && bank_ff == BANK_W'(b))) begin
               open_ff[b] <= 1'b0;
               pre_tmr_ff[b] <= PT_W'(PRECHARGE_CYC);
               // Ready tracks closed and timer empty one edge ahead, so the pin is a flop.
               bank_rdy_ff[b] <= PRECHARGE_CYC == 0;
            end else if (cmd == CMD_ACTIVATE && bank == BANK_W'(b)) begin
               open_ff[b] <= 1'b1;
               row_ff[b] <= cmd_pins.addr;
               bank_rdy_ff[b] <= 1'b0;
            end else if (pre_tmr_ff[b] != '0) begin
               pre_tmr_ff[b] <= pre_tmr_ff[b] - PT_W'(1);
               bank_rdy_ff[b] <= !open_ff[b] && pre_tmr_ff[b] == PT_W'(1);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Mode register.
   // ---------------------------------------------------------------
   // A load stores the operation code and restarts the mode set delay.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mode_ff <= MODE_RESET;
         mode_tmr_ff <= '0;
         mode_rdy_ff <= 1'b1;
      end else if (cmd == CMD_MODE_LOAD) begin
         mode_ff <= cmd_pins.addr;
         mode_tmr_ff <= MT_W'(MODE_SET_CYC);
         mode_rdy_ff <= MODE_SET_CYC == 0;
      end else if (mode_tmr_ff != '0) begin
         mode_tmr_ff <= mode_tmr_ff - MT_W'(1);
         // Ready rises on the same edge at which the timer reaches zero.
         mode_rdy_ff <= mode_tmr_ff == MT_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // Burst sequencer.
   // ---------------------------------------------------------------
   assign burst_end = (state_ff != ST_IDLE) && !full_ff && (beat_ff == mask_ff);
   // Sequential order counts up inside the block, interleaved order flips bits.
   always_comb begin
      if (mode_ff[MODE_BT_BIT] && !full_ff) begin
         nxt_col = (start_ff & ~mask_ff) | ((start_ff ^ (beat_ff + 8'h01)) & mask_ff);
      end else begin
         nxt_col = (start_ff & ~mask_ff) | ((start_ff + beat_ff + 8'h01) & mask_ff);
      end
   end
   // A new access truncates the running burst; burst stop ends it.
   always_comb begin
      nxt_state = state_ff;
      if (cmd == CMD_READ) begin
         nxt_state = ST_READ;
      end else if (cmd == CMD_WRITE) begin
         nxt_state = ST_WRITE;
      end else if (cmd == CMD_BURST_STOP || burst_end) begin
         nxt_state = ST_IDLE;
      end
   end
   // Burst address registers follow the state.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         bank_ff <= '0;
         mrow_ff <= '0;
         col_ff <= '0;
         start_ff <= '0;
         beat_ff <= '0;
         mask_ff <= '0;
         full_ff <= 1'b0;
         ap_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (cmd == CMD_READ || cmd == CMD_WRITE) begin
            bank_ff <= bank;
            mrow_ff <= row_ff[bank];
            col_ff <= cmd_pins.addr[COL_W-1:0];
            start_ff <= cmd_pins.addr[COL_W-1:0];
            beat_ff <= '0;
            // Single location writes when write burst mode asks for them.
            if (cmd == CMD_WRITE && mode_ff[MODE_WB_BIT]) begin
               mask_ff <= '0;
               full_ff <= 1'b0;
               ap_ff <= cmd_pins.addr[AUTO_PRE_BIT];
            end else begin
               mask_ff <= block_mask(mode_ff[MODE_BL_LSB +: 3]);
               full_ff <= mode_ff[MODE_BL_LSB +: 3] == BL_FULL_PAGE;
               ap_ff <= cmd_pins.addr[AUTO_PRE_BIT] && mode_ff[MODE_BL_LSB +: 3] != BL_FULL_PAGE;
            end
         end else if (state_ff != ST_IDLE && !burst_end) begin
            beat_ff <= beat_ff + 8'h01;
            col_ff <= nxt_col;
         end
      end
   end

   // ---------------------------------------------------------------
   // Write path.
   // ---------------------------------------------------------------
   // Data and lane enables are taken with the same edge as the mask.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wdata_ff <= '0;
         be_ff <= '0;
      end else begin
         wdata_ff <= dq_in;
         be_ff <= ~dqm;
      end
   end

   // ---------------------------------------------------------------
   // Read path.
   // ---------------------------------------------------------------
   assign cl_eff = (mode_ff[MODE_CL_LSB +: 3] == 3'h1) ? 2'h1 :
                   (mode_ff[MODE_CL_LSB +: 3] == 3'h2) ? 2'h2 : CL_MAX;
   assign hv = {vp2_ff, vp1_ff, state_ff == ST_READ, nxt_state == ST_READ};
   // Beats and data age through a short pipe; latency picks the tap.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         vp1_ff <= 1'b0;
         vp2_ff <= 1'b0;
         dp1_ff <= '0;
         dp2_ff <= '0;
         dqm_p1_ff <= '1;
         dqm_p2_ff <= '1;
         drive_ff <= 1'b0;
         valid_ff <= 1'b0;
         dq_out_ff <= '0;
         dq_oe_ff <= '0;
      end else begin
         vp1_ff <= state_ff == ST_READ;
         vp2_ff <= vp1_ff;
         dp1_ff <= mem_rdata;
         dp2_ff <= dp1_ff;
         dqm_p1_ff <= dqm;
         dqm_p2_ff <= dqm_p1_ff;
         drive_ff <= hv[cl_eff] || hv[cl_eff - 2'h1];
         valid_ff <= hv[cl_eff];
         unique case (cl_eff)
            2'h1: dq_out_ff <= mem_rdata;
            2'h2: dq_out_ff <= dp1_ff;
            default: dq_out_ff <= dp2_ff;
         endcase
         for (int l = 0; l < LANES; l++) begin
            dq_oe_ff[l] <= (hv[cl_eff] || hv[cl_eff - 2'h1]) && !dqm_p2_ff[l];
         end
      end
   end

   // ---------------------------------------------------------------
   // Refresh.
   // ---------------------------------------------------------------
   // Auto refresh and self refresh both walk the internal row counter.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ref_cnt_ff <= '0;
         ref_row_ff <= '0;
         ref_stb_ff <= 1'b0;
         self_ff <= 1'b0;
         self_div_ff <= '0;
      end else begin
         ref_stb_ff <= 1'b0;
         if (cmd == CMD_REFRESH) begin
            ref_row_ff <= ref_cnt_ff;
            ref_cnt_ff <= ref_cnt_ff + 11'h001;
            ref_stb_ff <= 1'b1;
            self_ff <= !cke;
            self_div_ff <= ST_W'(SELF_REF_CYC);
         end else if (self_ff) begin
            // Clock enable high ends self refresh; all else is ignored.
            self_ff <= !cke;
            if (self_div_ff == ST_W'(1)) begin
               ref_row_ff <= ref_cnt_ff;
               ref_cnt_ff <= ref_cnt_ff + 11'h001;
               ref_stb_ff <= 1'b1;
               self_div_ff <= ST_W'(SELF_REF_CYC);
            end else begin
               self_div_ff <= self_div_ff - ST_W'(1);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs.
   // ---------------------------------------------------------------
   assign dq_out = dq_out_ff;
   assign dq_oe = dq_oe_ff;
   assign mem_bank = bank_ff;
   assign mem_row = mrow_ff;
   assign mem_col = col_ff;
   assign mem_we = state_ff[2];
   assign mem_be = be_ff;
   assign mem_wdata = wdata_ff;
   assign refresh_strobe = ref_stb_ff;
   assign refresh_row = ref_row_ff;
   assign self_refresh = self_ff;
   assign mode_value = mode_ff;
   assign mode_ready = mode_rdy_ff;
   assign bank_open = open_ff;
   assign bank_ready = bank_rdy_ff;

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence rd_cl2_s;
      cmd == CMD_READ && cl_eff == 2'h2;
   endsequence
   sequence drive_then_valid_s;
      ##2 drive_ff ##1 valid_ff;
   endsequence
   inhibit_keeps_idle_a: assert property (cmd_pins.cs_n && state_ff == ST_IDLE |=> state_ff == ST_IDLE)
      else $error("Deselected cycle started a burst.");
   noop_keeps_mode_a: assert property (cmd == CMD_NO_OPERATION |=> $stable(mode_ff))
      else $error("No-operation changed the mode register.");
   activate_opens_row_a: assert property (cmd == CMD_ACTIVATE |=> open_ff[$past(bank)] && row_ff[$past(bank)] == $past(cmd_pins.addr))
      else $error("Activate did not open the named row.");
   read_takes_column_a: assert property (cmd == CMD_READ |=> state_ff == ST_READ && col_ff == $past(cmd_pins.addr[COL_W-1:0]))
      else $error("Read did not start at the given column.");
   auto_pre_closes_a: assert property (burst_end && ap_ff && !(cmd == CMD_ACTIVATE) |=> !open_ff[$past(bank_ff)])
      else $error("Auto precharge left the row open.");
   precharge_all_a: assert property (cmd == CMD_PRECHARGE && cmd_pins.addr[AUTO_PRE_BIT] |=> open_ff == '0)
      else $error("Precharge all left a bank open.");
   refresh_uses_count_a: assert property (cmd == CMD_REFRESH |=> refresh_strobe && refresh_row == $past(ref_cnt_ff) && self_ff == !$past(cke))
      else $error("Refresh row or mode wrong.");
   mode_load_stores_a: assert property (cmd == CMD_MODE_LOAD |=> mode_ff == $past(cmd_pins.addr) && !mode_ready)
      else $error("Mode load did not store the code.");
   read_mask_lane_a: assert property (dq_oe_ff[0] |-> !$past(dqm[0], MASK_LATENCY + 1))
      else $error("Masked read lane was driven.");
   write_mask_lane_a: assert property (mem_we |-> mem_be == ~$past(dqm))
      else $error("Write lanes do not follow the mask.");
   read_latency_two_a: assert property (rd_cl2_s |-> drive_then_valid_s)
      else $error("Read data not on time for latency two.");
   full_page_no_ap_a: assert property (cmd == CMD_READ && mode_ff[MODE_BL_LSB +: 3] == BL_FULL_PAGE |=> !ap_ff)
      else $error("Full page burst armed auto precharge.");
endmodule // sdram_command_decode_banks

// [verif/sdram_array_model.sv]
// Purpose: Behavioural cell array behind the mem_ ports of the decoder.
// Assumes: Small window of bank, two row bits and four column bits.
// Notes: Cells start as their own index in every byte.
`timescale 1ns/100ps
module sdram_array_model (
   input wire logic clock,
   input wire logic [1:0] mem_bank,
   input wire logic [10:0] mem_row,
   input wire logic [7:0] mem_col,
   input wire logic mem_we,
   input wire logic [3:0] mem_be,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata
);
   logic [31:0] cells [0:255]; // Storage cells.
   logic [7:0] idx; // Folded address.
   assign idx = {mem_bank, mem_row[1:0], mem_col[3:0]};
   assign mem_rdata = cells[idx];
   initial begin
      for (int i = 0; i < 256; i++) cells[i] = {4{8'(i)}};
   end
   // Only enabled byte lanes change, so masked lanes keep old data.
   always @(posedge clock) begin
      for (int l = 0; l < 4; l++) if (mem_we && mem_be[l]) cells[idx][8*l+:8] <= mem_wdata[8*l+:8];
   end
endmodule // sdram_array_model

// [verif/test_sdram_command_decode_banks.sv]
// Purpose: Self-checking bench for the command decoder and bank state.
// Assumes: Inputs change 1 ns after the rising edge; a command falls back to no-operation on its taking edge.
// Notes: Self refresh interval shortened to 8 cycles.
`timescale 1ns/100ps
module test_sdram_command_decode_banks import sdram_cmd_pkg::*;;
   logic clock = 0, sys_rst = 1, cke = 1;
   cmd_pins_s cmd_pins = {1'b1, ENC_NO_OPERATION, 13'h0};
   logic [3:0] dqm = 0, dq_oe, mem_be, bank_open, bank_ready;
   logic [31:0] dq_in = 0, dq_out, mem_rdata, mem_wdata;
   logic [1:0] mem_bank;
   logic [10:0] mem_row, refresh_row, mode_value;
   logic [7:0] mem_col;
   logic mem_we, refresh_strobe, self_refresh, mode_ready;
   int fail_count = 0, compares = 0;
   sdram_command_decode_banks #(.SELF_REF_CYC(8)) u_sdram_command_decode_banks (.clock(clock),
      .sys_rst(sys_rst), .cke(cke), .cmd_pins(cmd_pins), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .mem_rdata(mem_rdata), .mem_bank(mem_bank), .mem_row(mem_row), .mem_col(mem_col),
      .mem_we(mem_we), .mem_be(mem_be), .mem_wdata(mem_wdata), .refresh_strobe(refresh_strobe),
      .refresh_row(refresh_row), .self_refresh(self_refresh), .mode_value(mode_value),
      .mode_ready(mode_ready), .bank_open(bank_open), .bank_ready(bank_ready));
   sdram_array_model u_sdram_array_model (.clock(clock), .mem_bank(mem_bank), .mem_row(mem_row),
      .mem_col(mem_col), .mem_we(mem_we), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   initial begin
      forever #5 clock = ~clock;
   end
   // Compares one value and counts it.
   task check(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         fail_count++;
      end
   endtask
   task step(int n);
      repeat (n) @(posedge clock) #1;
   endtask
   // Drives one command for one edge, then returns to no_operation.
   task issue(logic csn, logic [2:0] enc, logic [1:0] bank, logic [10:0] addr);
      cmd_pins = {csn, enc, bank, addr};
      @(posedge clock);
      // Falling back on the taking edge keeps one assignment per time step.
      cmd_pins <= {1'b0, ENC_NO_OPERATION, 13'h0};
      #1;
   endtask
   task t_reset;
      check("mode", mode_value, 11'h020);
      check("ready", {mode_ready, bank_ready, bank_open, dq_oe}, 13'h1F00);
   endtask
   task t_access;
      issue(1, ENC_ACTIVATE, 1, 11'h005);
      check("deselect", bank_open, 4'h0);
      issue(0, ENC_ACTIVATE, 2, 11'h005);
      check("act", bank_open, 4'h4);
      issue(0, ENC_NO_OPERATION, 3, 11'h005);
      check("nop", bank_open, 4'h4);
      dqm = 4'b0101;
      dq_in = 32'hA1B2C3D4;
      issue(0, ENC_WRITE, 2, 11'h003);
      check("wr", {mem_we, mem_be, mem_bank, mem_row, mem_col}, {1'b1, 4'b1010, 2'h2, 11'h005, 8'h03});
      check("wdata", mem_wdata, 32'hA1B2C3D4);
      dqm = 4'b0011;
      step(1);
      issue(0, ENC_READ, 2, 11'h003);
      check("oe early", dq_oe, 4'h0);
      step(1);
      check("oe", dq_oe, 4'b1100);
      step(1);
      check("rd", {dq_oe, dq_out[31:16]}, {4'b1100, 16'hA193});
      check("open", bank_open, 4'h4);
      dqm = 0;
      issue(0, ENC_WRITE, 2, 11'h404);
      step(3);
      check("autopre", bank_open, 4'h0);
   endtask
   task t_precharge;
      issue(0, ENC_ACTIVATE, 0, 11'h001);
      issue(0, ENC_ACTIVATE, 1, 11'h002);
      issue(0, ENC_PRECHARGE, 0, 11'h000);
      check("pre one", {bank_open, bank_ready[0]}, 5'b00100);
      issue(0, ENC_PRECHARGE, 0, 11'h400);
      check("pre all", bank_open, 4'h0);
      step(PRECHARGE_PERIOD_CYC + 1);
      check("rdy", bank_ready, 4'hF);
   endtask
   task t_refresh;
      issue(0, ENC_REFRESH, 3, 11'h7FF);
      check("ar", {refresh_strobe, self_refresh, refresh_row}, {2'b10, 11'h000});
      issue(0, ENC_REFRESH, 0, 11'h155);
      check("ar2", refresh_row, 11'h001);
      cke = 0;
      issue(0, ENC_REFRESH, 0, 11'h000);
      check("sr", {self_refresh, refresh_row}, {1'b1, 11'h002});
      issue(0, ENC_ACTIVATE, 3, 11'h001);
      for (int i = 0; i < 12 && refresh_strobe !== 1'b1; i++) step(1);
      check("sr row", {refresh_strobe, refresh_row}, {1'b1, 11'h003});
      cke = 1;
      step(2);
      check("sr exit", {self_refresh, bank_open}, 5'h0);
   endtask
   task t_mode;
      issue(0, ENC_MODE_LOAD, 0, 11'h027);
      check("mode", {mode_ready, mode_value}, {1'b0, 11'h027});
      for (int i = 0; i < 10 && mode_ready !== 1'b1; i++) step(1);
      issue(0, ENC_ACTIVATE, 0, 11'h001);
      step(2);
      issue(0, ENC_READ, 0, 11'h400);
      step(4);
      issue(0, ENC_BURST_STOP, 0, 11'h000);
      step(3);
      check("fullpage", {mode_ready, bank_open, dq_oe}, 9'h110);
   endtask
   // Interleaved burst of four at read latency three, loaded while every bank is idle.
   task t_burst;
      issue(0, ENC_PRECHARGE, 0, 11'h400);
      step(PRECHARGE_PERIOD_CYC);
      issue(0, ENC_MODE_LOAD, 0, 11'h03A);
      step(MODE_SET_DELAY_CYC);
      issue(0, ENC_ACTIVATE, 1, 11'h002);
      issue(0, ENC_READ, 1, 11'h001);
      step(1);
      check("cl3 early", dq_oe, 4'h0);
      step(1);
      check("cl3 oe", dq_oe, 4'hF);
      step(1);
      check("beat0", dq_out, 32'h61616161);
      step(1);
      check("beat1", dq_out, 32'h60606060);
      step(1);
      check("beat2", dq_out, 32'h63636363);
      step(1);
      check("beat3", dq_out, 32'h62626262);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      summarize();
   end
   initial begin
      step(10);
      sys_rst = 0;
      t_reset();
      t_access();
      t_precharge();
      t_refresh();
      t_mode();
      t_burst();
      summarize();
   end
endmodule // test_sdram_command_decode_banks
